// ==== logic/pwp_level_check.sv ====
// Decision on a first- or second-level table entry during a walk.
// Assumes the entry has just been returned by physical memory.
`default_nettype none

module pwp_level_check (
  input wire logic [pwp_pkg::PTE_W-1:0] pte_i, // Entry read
  output logic walk_on_o, // Continue to next level
  output logic acv_o, // Access violation
  output logic tnv_o // Translation not valid
);
  import pwp_pkg::*;

  // ****************************************************************
  // Valid entries pass; protection bits are not looked at
  // ****************************************************************
  assign walk_on_o = pte_i[PTE_VALID]; // R09
  // An invalid entry without kernel read means no lower tables exist
  assign acv_o = !pte_i[PTE_VALID] && !pte_i[PTE_KRE]; // R10
  assign tnv_o = !pte_i[PTE_VALID] && pte_i[PTE_KRE]; // R10

endmodule : pwp_level_check

`default_nettype wire

// ==== logic/pwp_perm_check.sv ====
// Protection check of one page against the current mode and access.
// Assumes a packed permission nibble laid out as in pwp_pkg.
`default_nettype none

module pwp_perm_check (
  input wire logic user_i, // Current mode is user
  input wire logic write_i, // Access is a store
  input wire logic [3:0] perm_i, // {uwe, ure, kwe, kre}
  output logic acv_o // Access is illegal
);
  import pwp_pkg::*;

  // ****************************************************************
  // Mode-selected enable
  // ****************************************************************
  // Read and write enables are independent per mode
  logic rd_ok;
  logic wr_ok;
  assign rd_ok = user_i ? perm_i[PERM_URE] : perm_i[PERM_KRE]; // R03
  assign wr_ok = user_i ? perm_i[PERM_UWE] : perm_i[PERM_KWE]; // R03
  assign acv_o = write_i ? !wr_ok : !rd_ok; // R12

endmodule : pwp_perm_check

`default_nettype wire

// ==== logic/pwp_pkg.sv ====
// Shared constants for the page walk and protection check block.
// Assumes a single core clock and 8 KB pages with 8-byte table entries.
`default_nettype none

package pwp_pkg;

  // ****************************************************************
  // Page geometry
  // ****************************************************************
  localparam int PAGE_BITS = 13; // Byte-within-page bits
  localparam int ENTRY_SHIFT = 3; // 8 bytes per table entry
  localparam logic [2:0] ENTRY_ZERO = 3'h0;
  localparam int IDX_BITS = PAGE_BITS - ENTRY_SHIFT; // Index per level
  localparam int VA_SIZE = PAGE_BITS + 3 * IDX_BITS; // Implemented VA
  localparam int VPN_W = VA_SIZE - PAGE_BITS;
  localparam int ADDR_W = 64;
  localparam int PTE_W = 64;

  // ****************************************************************
  // Page table entry fields
  // ****************************************************************
  localparam int PTE_VALID = 0;
  localparam int PTE_GLOBAL = 4;
  localparam int PTE_KRE = 8;
  localparam int PTE_URE = 9;
  localparam int PTE_KWE = 12;
  localparam int PTE_UWE = 13;
  localparam int PFN_LO = 32;
  localparam int PFN_HI = 63;
  localparam int FRAME_W = PFN_HI - PFN_LO + 1;
  localparam int PA_W = FRAME_W + PAGE_BITS;

  // Packed permission nibble kept in the translation buffer
  localparam int PERM_KRE = 0;
  localparam int PERM_KWE = 1;
  localparam int PERM_URE = 2;
  localparam int PERM_UWE = 3;

  // ****************************************************************
  // Modes, segments, access kinds, walk states
  // ****************************************************************
  localparam logic MODE_USER = 1'h1;
  localparam logic MODE_KERNEL = 1'h0;
  localparam logic [1:0] KSEG_SEL = 2'h2; // Top two VA bits of kernel seg

  typedef enum logic [1:0] {
    KIND_LOAD,
    KIND_FETCH,
    KIND_STORE
  } pwp_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LEVEL1,
    ST_LEVEL2,
    ST_LEVEL3
  } pwp_state_e;

endpackage : pwp_pkg

`default_nettype wire

// ==== logic/pwp_walker.sv ====
// Page walk, protection check and tagged translation buffer.
// Assumes table memory answers on the core clock with a one-cycle ack.
//
// Behaviour
// (R01) Loads and instruction fetches check as reads; stores as writes.
// (R02) Mode input: 1 means user, 0 means kernel.
// (R03) User segment pages check read and write per mode independently.
// (R04) Kernel segment: kernel may read and write, user gets nothing.
// (R05) An illegal access for the mode and protection raises violation.
// (R06) Physical walk has three levels, starting at table base frame.
// (R07) Entry address is base frame times page size plus 8 times index.
// (R08) Physical address is final frame number joined with page offset.
// (R09) Valid upper-level entries: protection ignored, final entry decides.
// (R10) Invalid upper entry: violation if kernel read clear, else not valid.
// (R11) Non sign-extended virtual address raises violation before walking.
// (R12) Final entry: fault when mode's write or read enable is clear.
// (R13) Software aligns virtual table region and loads table pointer.
// (R14) Virtual mode: base ORed with shifted index, low three bits zero.
// (R15) Software makes valid upper entries grant kernel read.
// (R16) Context swap without tagging drops non-global translations.
// (R17) Invalidate-all and invalidate-non-global operations exist.
// (R18) Buffer never holds entries from invalid table entries.
// (R19) N tag bits: 2^N-3 process codes, one global, one invalid.
// (R20) Software keeps buffers consistent when processes move CPUs.
// (R21) Frame number comes from entry bits 63:32.
// (R22) User write enable is bit 13, kernel write enable bit 12.
// (R23) User read enable is bit 9, kernel read enable bit 8.
// (R24) Entry bit 0 is the valid flag.
// (R25) Buffer hit with matching tag or global checks without a walk.
`default_nettype none

module pwp_walker #(
  parameter int ENTRIES = 8, // Translation buffer entries
  parameter int TAG_W = 4 // Process tag width
) (
  input wire logic clk_i, // Core clock, 20 MHz
  input wire logic sys_rst_i, // Synchronous reset, active high
  input wire logic req_valid_i, // Access request
  input wire logic [pwp_pkg::ADDR_W-1:0] req_va_i, // Virtual address
  input wire pwp_pkg::pwp_kind_e req_kind_i, // Load, fetch or store
  input wire logic current_mode_field_i, // 1 user, 0 kernel
  input wire logic [pwp_pkg::FRAME_W-1:0] table_base_frame_reg_i, // L1
  input wire logic vpt_mode_i, // Fetch final entry virtually
  input wire logic [pwp_pkg::ADDR_W-1:0] virtual_table_base_i, // Pointer
  input wire logic tag_enable_i, // Process tags implemented
  input wire logic [TAG_W-1:0] process_tag_i, // Current process tag
  input wire logic ctx_swap_i, // Context swap pulse
  input wire logic inval_all_i, // Invalidate whole buffer pulse
  input wire logic inval_proc_i, // Invalidate non-global pulse
  output logic mem_req_o, // Table read request, held to ack
  output logic mem_virt_o, // Address is virtual
  output logic [pwp_pkg::ADDR_W-1:0] mem_addr_o, // Table entry address
  input wire logic mem_ack_i, // Read data valid
  input wire logic [pwp_pkg::PTE_W-1:0] mem_data_i, // Entry read
  output logic busy_o, // Walk in progress
  output logic done_o, // Result pulse
  output logic fault_acv_o, // Access violation with done
  output logic fault_tnv_o, // Translation not valid with done
  output logic tb_hit_o, // Result came from buffer
  output logic [pwp_pkg::PA_W-1:0] pa_o // Physical address with done
);
  import pwp_pkg::*;

  localparam int IDX_W = $clog2(ENTRIES);
  localparam logic [TAG_W-1:0] TAG_INVALID = {TAG_W{1'b1}};
  localparam logic [TAG_W-1:0] TAG_GLOBAL = TAG_INVALID - 1'b1;
  localparam logic [TAG_W-1:0] TAG_LIMIT = TAG_INVALID - 2'h2;

  // ****************************************************************
  // Request decode
  // ****************************************************************
  pwp_state_e state_ff;
  logic take;
  logic is_write;
  logic is_user;
  logic noncanon;
  logic kseg;
  logic [VPN_W-1:0] req_vpn;
  assign take = req_valid_i && state_ff == ST_IDLE;
  assign is_write = req_kind_i == KIND_STORE; // R01
  assign is_user = current_mode_field_i == MODE_USER; // R02
  // Bits above the implemented range must copy the top bit
  assign noncanon = req_va_i[ADDR_W-1:VA_SIZE]
                    != {(ADDR_W-VA_SIZE){req_va_i[VA_SIZE-1]}}; // R11
  assign kseg = req_va_i[VA_SIZE-1 -: 2] == KSEG_SEL;
  assign req_vpn = req_va_i[VA_SIZE-1:PAGE_BITS];

  // Without tagging every process shares code zero
  logic [TAG_W-1:0] cur_tag;
  logic tag_ok;
  assign cur_tag = tag_enable_i ? process_tag_i : '0;
  assign tag_ok = cur_tag < TAG_LIMIT; // R19

  // ****************************************************************
  // Translation buffer storage and lookup
  // ****************************************************************
  logic [VPN_W-1:0] tb_vpn_ff [ENTRIES];
  logic [TAG_W-1:0] tb_tag_ff [ENTRIES];
  logic [FRAME_W-1:0] tb_frame_ff [ENTRIES];
  logic [3:0] tb_perm_ff [ENTRIES];
  logic [IDX_W-1:0] rr_ff;

  logic hit;
  logic [IDX_W-1:0] hit_idx;
  // Tag code alone marks an empty slot, so no separate valid bit
  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (tb_tag_ff[i] != TAG_INVALID && tb_vpn_ff[i] == req_vpn &&
          (tb_tag_ff[i] == TAG_GLOBAL || tb_tag_ff[i] == cur_tag)) begin
        hit = 1'b1; // R25
        hit_idx = IDX_W'(i);
      end
    end
  end

  // ****************************************************************
  // Protection and level checks
  // ****************************************************************
  logic [ADDR_W-1:0] va_ff;
  logic write_ff;
  logic user_ff;
  logic hit_acv;
  logic l3_acv;
  logic lvl_on;
  logic lvl_acv;
  logic lvl_tnv;
  logic [3:0] l3_perm;
  assign l3_perm = {mem_data_i[PTE_UWE], mem_data_i[PTE_URE],
                    mem_data_i[PTE_KWE], mem_data_i[PTE_KRE]}; // R22 R23

  // Cached permissions, current request
  pwp_perm_check u_hit_perm (
    .user_i(is_user),
    .write_i(is_write),
    .perm_i(tb_perm_ff[hit_idx]),
    .acv_o(hit_acv)
  );

  // Final-level entry, latched request
  pwp_perm_check u_l3_perm (
    .user_i(user_ff),
    .write_i(write_ff),
    .perm_i(l3_perm),
    .acv_o(l3_acv)
  );

  pwp_level_check u_lvl (
    .pte_i(mem_data_i),
    .walk_on_o(lvl_on),
    .acv_o(lvl_acv),
    .tnv_o(lvl_tnv)
  );

  // ****************************************************************
  // Table entry addresses
  // ****************************************************************
  logic [ADDR_W-1:0] l1_addr;
  logic [ADDR_W-1:0] vpt_or;
  logic [ADDR_W-1:0] vpt_addr;
  logic [IDX_BITS-1:0] next_idx;
  logic [ADDR_W-1:0] next_addr;
  // Frame times page size plus 8 times index is a plain concatenation
  assign l1_addr = ADDR_W'({table_base_frame_reg_i,
                            req_va_i[VA_SIZE-1 -: IDX_BITS],
                            ENTRY_ZERO}); // R06 R07
  assign vpt_or = virtual_table_base_i
                  | ADDR_W'({req_vpn, ENTRY_ZERO}); // R14
  assign vpt_addr = {vpt_or[ADDR_W-1:ENTRY_SHIFT], ENTRY_ZERO}; // R14
  assign next_idx = state_ff == ST_LEVEL1
                    ? va_ff[VA_SIZE-IDX_BITS-1 -: IDX_BITS]
                    : va_ff[PAGE_BITS +: IDX_BITS];
  assign next_addr = ADDR_W'({mem_data_i[PFN_HI:PFN_LO], next_idx,
                              ENTRY_ZERO}); // R07 R21

  // ****************************************************************
  // Completion decode
  // ****************************************************************
  logic fin;
  logic fin_acv;
  logic fin_tnv;
  logic fin_hit;
  logic [PA_W-1:0] fin_pa;
  logic [PA_W-1:0] pa_ff;
  logic fill_en;
  // Protection of the final entry is judged before its valid bit
  always_comb begin
    fin = 1'b0;
    fin_acv = 1'b0;
    fin_tnv = 1'b0;
    fin_hit = 1'b0;
    fin_pa = pa_ff;
    fill_en = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (take && noncanon) begin
          fin = 1'b1;
          fin_acv = 1'b1; // R11 R05
        end else if (take && kseg) begin
          fin = 1'b1;
          fin_acv = is_user; // R04
          fin_pa = req_va_i[PA_W-1:0];
        end else if (take && hit) begin
          fin = 1'b1;
          fin_hit = 1'b1;
          fin_acv = hit_acv; // R25 R05
          fin_pa = {tb_frame_ff[hit_idx], req_va_i[PAGE_BITS-1:0]};
        end
      end
      ST_LEVEL1, ST_LEVEL2: begin
        if (mem_ack_i && !lvl_on) begin
          fin = 1'b1;
          fin_acv = lvl_acv; // R10
          fin_tnv = lvl_tnv; // R10
        end
      end
      ST_LEVEL3: begin
        if (mem_ack_i) begin
          fin = 1'b1;
          fin_acv = l3_acv; // R12 R05
          fin_tnv = !l3_acv && !mem_data_i[PTE_VALID]; // R24
          fin_pa = {mem_data_i[PFN_HI:PFN_LO],
                    va_ff[PAGE_BITS-1:0]}; // R08 R21
          // Only valid, permitted entries are remembered
          fill_en = !l3_acv && mem_data_i[PTE_VALID] && tag_ok; // R18
        end
      end
    endcase
  end

  // ****************************************************************
  // Walk state
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (take && !fin) begin
            state_ff <= vpt_mode_i ? ST_LEVEL3 : ST_LEVEL1; // R14 R06
          end
        end
        ST_LEVEL1: begin
          if (mem_ack_i) begin
            state_ff <= lvl_on ? ST_LEVEL2 : ST_IDLE; // R09
          end
        end
        ST_LEVEL2: begin
          if (mem_ack_i) begin
            state_ff <= lvl_on ? ST_LEVEL3 : ST_IDLE; // R09
          end
        end
        ST_LEVEL3: begin
          if (mem_ack_i) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Latched request for the length of a walk
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      va_ff <= '0;
      write_ff <= 1'b0;
      user_ff <= 1'b0;
    end else if (take) begin
      va_ff <= req_va_i;
      write_ff <= is_write; // R01
      user_ff <= is_user; // R02
    end
  end

  // ****************************************************************
  // Table memory port
  // ****************************************************************
  logic mem_req_ff;
  logic mem_virt_ff;
  logic [ADDR_W-1:0] mem_addr_ff;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mem_req_ff <= 1'b0;
      mem_virt_ff <= 1'b0;
      mem_addr_ff <= '0;
    end else if (take && !fin) begin
      mem_req_ff <= 1'b1;
      mem_virt_ff <= vpt_mode_i;
      mem_addr_ff <= vpt_mode_i ? vpt_addr : l1_addr; // R14 R07
    end else if (mem_ack_i && lvl_on &&
                 (state_ff == ST_LEVEL1 || state_ff == ST_LEVEL2)) begin
      mem_virt_ff <= 1'b0;
      mem_addr_ff <= next_addr; // R07
    end else if (mem_ack_i) begin
      mem_req_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Results
  // ****************************************************************
  logic busy_ff;
  logic done_ff;
  logic acv_ff;
  logic tnv_ff;
  logic hit_ff;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      acv_ff <= 1'b0;
      tnv_ff <= 1'b0;
      hit_ff <= 1'b0;
      pa_ff <= '0;
    end else begin
      busy_ff <= (take && !fin) || (busy_ff && !fin);
      done_ff <= fin;
      if (fin) begin
        acv_ff <= fin_acv; // R05
        tnv_ff <= fin_tnv;
        hit_ff <= fin_hit;
        pa_ff <= fin_pa;
      end
    end
  end

  // ****************************************************************
  // Buffer maintenance
  // ****************************************************************
  // A fill in the same cycle as an invalidation survives it, so a
  // translation finished during a flush is not silently lost
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < ENTRIES; i++) begin
        tb_tag_ff[i] <= TAG_INVALID;
        tb_vpn_ff[i] <= '0;
        tb_frame_ff[i] <= '0;
        tb_perm_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (inval_all_i) begin
          tb_tag_ff[i] <= TAG_INVALID; // R17
        end else if ((inval_proc_i || (ctx_swap_i && !tag_enable_i)) &&
                     tb_tag_ff[i] != TAG_GLOBAL) begin
          tb_tag_ff[i] <= TAG_INVALID; // R17 R16
        end
      end
      if (fill_en) begin
        tb_tag_ff[rr_ff] <= mem_data_i[PTE_GLOBAL] ? TAG_GLOBAL
                                                   : cur_tag; // R19
        tb_vpn_ff[rr_ff] <= va_ff[VA_SIZE-1:PAGE_BITS];
        tb_frame_ff[rr_ff] <= mem_data_i[PFN_HI:PFN_LO];
        tb_perm_ff[rr_ff] <= l3_perm;
      end
    end
  end

  // Round-robin victim choice; cheap and fair enough for few entries
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rr_ff <= '0;
    end else if (fill_en) begin
      rr_ff <= rr_ff + 1'b1;
    end
  end

  assign mem_req_o = mem_req_ff;
  assign mem_virt_o = mem_virt_ff;
  assign mem_addr_o = mem_addr_ff;
  assign busy_o = busy_ff;
  assign done_o = done_ff;
  assign fault_acv_o = acv_ff;
  assign fault_tnv_o = tnv_ff;
  assign tb_hit_o = hit_ff;
  assign pa_o = pa_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic any_valid;
  always_comb begin
    any_valid = 1'b0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (tb_tag_ff[i] != TAG_INVALID) begin
        any_valid = 1'b1;
      end
    end
  end

  sequence s_acv_done;
    done_o && fault_acv_o && !fault_tnv_o;
  endsequence
  sequence s_tnv_done;
    done_o && fault_tnv_o && !fault_acv_o;
  endsequence

  property p_kseg_user;
    take && !noncanon && kseg && is_user |=> s_acv_done;
  endproperty
  a_kseg_user: assert property (p_kseg_user) // R04
    else $error("user kernel-segment access not refused");

  property p_noncanon;
    take && noncanon |=> s_acv_done ##1 !done_o;
  endproperty
  a_noncanon: assert property (p_noncanon) // R11
    else $error("non sign-extended address not refused");

  property p_l1_addr;
    take && !noncanon && !kseg && !hit && !vpt_mode_i
      |=> mem_req_o && !mem_virt_o && mem_addr_o == $past(l1_addr);
  endproperty
  a_l1_addr: assert property (p_l1_addr) // R07
    else $error("first level address wrong");

  property p_vpt_align;
    mem_req_o && mem_virt_o |-> mem_addr_o[ENTRY_SHIFT-1:0] == ENTRY_ZERO;
  endproperty
  a_vpt_align: assert property (p_vpt_align) // R14
    else $error("virtual entry address not aligned");

  property p_fill_valid;
    fill_en |-> mem_data_i[PTE_VALID] && state_ff == ST_LEVEL3;
  endproperty
  a_fill_valid: assert property (p_fill_valid) // R18
    else $error("invalid entry cached");

  property p_inval_all;
    inval_all_i && !fill_en |=> !any_valid;
  endproperty
  a_inval_all: assert property (p_inval_all) // R17
    else $error("buffer not empty after invalidate all");

  property p_hit_nowalk;
    take && !noncanon && !kseg && hit |=> done_o && tb_hit_o
      && !mem_req_o ##1 !mem_req_o;
  endproperty
  a_hit_nowalk: assert property (p_hit_nowalk) // R25
    else $error("buffer hit started a walk");

  property p_upper_tnv;
    (state_ff == ST_LEVEL1 || state_ff == ST_LEVEL2) && mem_ack_i &&
      !mem_data_i[PTE_VALID] && mem_data_i[PTE_KRE] |=> s_tnv_done;
  endproperty
  a_upper_tnv: assert property (p_upper_tnv) // R10
    else $error("invalid upper entry did not give not-valid");

  property p_user_store;
    state_ff == ST_LEVEL3 && mem_ack_i && user_ff && write_ff &&
      !mem_data_i[PTE_UWE] |=> s_acv_done and !busy_o;
  endproperty
  a_user_store: assert property (p_user_store) // R12
    else $error("user store without write enable allowed");

endmodule : pwp_walker

`default_nettype wire

// ==== verification/pwp_mem_model.sv ====
// Behavioural table memory that answers the walk reads of pwp_walker.
// Assumes the block holds its request and address until the ack edge.
`default_nettype none

module pwp_mem_model (
  input wire logic clk_i, // Core clock
  input wire logic sys_rst_i, // Synchronous reset
  input wire logic slow_i, // Answer after three cycles, not one
  input wire logic mem_req_i, // Table read request
  input wire logic mem_virt_i, // Address is virtual
  input wire logic [63:0] mem_addr_i, // Entry address
  output logic mem_ack_o, // One-cycle answer
  output logic [63:0] mem_data_o // Entry read
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] entries [logic [63:0]]; // Filled by the bench
  logic [63:0] last_addr; // Last address answered
  logic last_virt;
  logic [1:0] cnt_ff;

  // ****************************************************************
  // Answer
  // ****************************************************************
  // An idle data bus shows the inverse of its last value, not stale data
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mem_ack_o <= 1'b0;
      cnt_ff <= 2'h0;
      mem_data_o <= 64'h0;
    end else if (mem_ack_o || !mem_req_i) begin
      mem_ack_o <= 1'b0;
      cnt_ff <= 2'h0;
      mem_data_o <= ~mem_data_o;
    end else if (cnt_ff == (slow_i ? 2'h2 : 2'h0)) begin
      mem_ack_o <= 1'b1;
      mem_data_o <= entries.exists(mem_addr_i) ? entries[mem_addr_i] : 64'h0;
      last_addr <= mem_addr_i;
      last_virt <= mem_virt_i;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      mem_data_o <= ~mem_data_o;
    end
  end
endmodule // pwp_mem_model

`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench of pwp_walker with a behavioural table memory.
// Assumes pwp_pkg, the design files and pwp_mem_model compile first.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pwp_pkg::*;
  typedef struct packed {
    logic [63:0] va;
    pwp_kind_e kind;
    logic mode;
    logic acv;
    logic tnv;
    logic hit;
    logic [44:0] pa;
  } pwp_row_s;
  localparam logic [63:0] KV = 64'hFFFF_FC00_0000_1234;
  localparam pwp_row_s ROWS [15] = '{
    '{KV, KIND_LOAD, 1'b0, 1'b0, 1'b0, 1'b0, 45'h1C00_0000_1234},
    '{KV, KIND_STORE, 1'b1, 1'b1, 1'b0, 1'b0, 45'h0},
    '{64'h0800_0000_0000, KIND_LOAD, 1'b0, 1'b1, 1'b0, 1'b0, 45'h0},
    '{64'h2123, KIND_LOAD, 1'b1, 1'b0, 1'b0, 1'b0, 45'h20_2123},
    '{64'h2123, KIND_STORE, 1'b1, 1'b0, 1'b0, 1'b1, 45'h20_2123},
    '{64'h4123, KIND_STORE, 1'b0, 1'b0, 1'b0, 1'b0, 45'h20_4123},
    '{64'h4123, KIND_LOAD, 1'b1, 1'b1, 1'b0, 1'b1, 45'h0},
    '{64'h6123, KIND_FETCH, 1'b1, 1'b0, 1'b0, 1'b0, 45'h20_6123},
    '{64'h6123, KIND_STORE, 1'b0, 1'b1, 1'b0, 1'b1, 45'h0},
    '{64'h8123, KIND_LOAD, 1'b0, 1'b0, 1'b1, 1'b0, 45'h0},
    '{64'h8123, KIND_STORE, 1'b1, 1'b0, 1'b1, 1'b0, 45'h0},
    '{64'hA123, KIND_FETCH, 1'b0, 1'b1, 1'b0, 1'b0, 45'h0},
    '{64'h2_0000_0123, KIND_LOAD, 1'b0, 1'b1, 1'b0, 1'b0, 45'h0},
    '{64'h4_0000_0123, KIND_LOAD, 1'b1, 1'b0, 1'b1, 1'b0, 45'h0},
    '{64'h6123, KIND_LOAD, 1'b1, 1'b0, 1'b0, 1'b1, 45'h20_6123}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic [63:0] va = 64'h0;
  pwp_kind_e kind = KIND_LOAD;
  logic mode = 1'b0;
  logic vpt = 1'b0;
  logic [63:0] vbase = 64'h0;
  logic tag_en = 1'b1;
  logic swap = 1'b0;
  logic ia = 1'b0;
  logic ip = 1'b0;
  logic slow = 1'b0;
  logic [3:0] ptag = 4'h0;
  logic mem_req, mem_virt, ack, busy, done, acv, tnv, hit;
  logic [63:0] mem_addr, data;
  logic [44:0] pa;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;

  pwp_walker DUT (.clk_i(clk), .sys_rst_i(rst), .req_valid_i(req_valid),
    .req_va_i(va), .req_kind_i(kind), .current_mode_field_i(mode),
    .table_base_frame_reg_i(32'h1), .vpt_mode_i(vpt),
    .virtual_table_base_i(vbase), .tag_enable_i(tag_en),
    .process_tag_i(ptag), .ctx_swap_i(swap), .inval_all_i(ia),
    .inval_proc_i(ip), .mem_req_o(mem_req), .mem_virt_o(mem_virt),
    .mem_addr_o(mem_addr), .mem_ack_i(ack), .mem_data_i(data),
    .busy_o(busy), .done_o(done), .fault_acv_o(acv), .fault_tnv_o(tnv),
    .tb_hit_o(hit), .pa_o(pa));
  pwp_mem_model mem (.clk_i(clk), .sys_rst_i(rst), .slow_i(slow),
    .mem_req_i(mem_req), .mem_virt_i(mem_virt), .mem_addr_i(mem_addr),
    .mem_ack_o(ack), .mem_data_o(data));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Entry built field by field: {uwe, kwe, ure, kre} in p
  function automatic logic [63:0] pte(logic [31:0] f, logic [3:0] p,
                                      logic g, logic v);
    return {f, 18'h0, p[3:2], 2'h0, p[1:0], 3'h0, g, 3'h0, v};
  endfunction

  task automatic check(logic [63:0] seen, logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Request for one edge, then a bounded wait for the result pulse
  task automatic access(logic [63:0] a, pwp_kind_e k, logic m);
    int n = 0;
    @(negedge clk);
    va = a;
    kind = k;
    mode = m;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(done, 1'b1);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    forever #25 clk = ~clk;
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    mem.entries[64'h2000] = pte(32'h2, 4'h1, 1'b0, 1'b1);
    mem.entries[64'h2010] = 64'h100;
    mem.entries[64'h4000] = pte(32'h3, 4'h1, 1'b0, 1'b1);
    mem.entries[64'h6008] = pte(32'h101, 4'hF, 1'b0, 1'b1);
    mem.entries[64'h6010] = pte(32'h102, 4'h5, 1'b0, 1'b1);
    mem.entries[64'h6018] = pte(32'h103, 4'h3, 1'b0, 1'b1);
    mem.entries[64'h6020] = pte(32'h104, 4'hF, 1'b0, 1'b0);
    mem.entries[64'h6028] = pte(32'h105, 4'h0, 1'b0, 1'b1);
    mem.entries[64'h6030] = pte(32'h106, 4'hF, 1'b1, 1'b1);
    mem.entries[64'h2_0000_0038] = pte(32'h207, 4'hF, 1'b0, 1'b1);
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check({busy, done, mem_req}, 3'h0);
    foreach (ROWS[i]) begin
      slow = i[0];
      access(ROWS[i].va, ROWS[i].kind, ROWS[i].mode);
      check(acv, ROWS[i].acv);
      check(tnv, ROWS[i].tnv);
      check(hit, ROWS[i].hit);
      if (!ROWS[i].acv && !ROWS[i].tnv)
        check(pa, ROWS[i].pa);
    end
    // Tag codes 13 and up are never cached; a foreign tag never hits
    ptag = 4'hD;
    access(64'h4123, KIND_STORE, 1'b1);
    check(acv, 1'b1);
    access(64'h4123, KIND_STORE, 1'b0);
    access(64'h4123, KIND_STORE, 1'b0);
    check(hit, 1'b0);
    ptag = 4'h1;
    access(64'h2123, KIND_LOAD, 1'b0);
    check(hit, 1'b0);
    ptag = 4'h0;
    // Global page survives the non-global drops, others do not
    access(64'hC123, KIND_LOAD, 1'b0);
    pulse(ip);
    access(64'h2123, KIND_LOAD, 1'b0);
    check(hit, 1'b0);
    access(64'hC123, KIND_LOAD, 1'b0);
    check(hit, 1'b1);
    tag_en = 1'b0;
    pulse(swap);
    access(64'h2123, KIND_LOAD, 1'b0);
    check(hit, 1'b0);
    access(64'hC123, KIND_LOAD, 1'b0);
    check(hit, 1'b1);
    pulse(ia);
    access(64'hC123, KIND_LOAD, 1'b0);
    check(hit, 1'b0);
    check(mem.last_addr, 64'h6030);
    // Table window aligned to 33 low zero bits
    vbase = 64'h2_0000_0000;
    vpt = 1'b1;
    access(64'hE123, KIND_LOAD, 1'b1);
    check(mem.last_addr, 64'h2_0000_0038);
    check(mem.last_virt, 1'b1);
    check(pa, 45'h40_E123);
    report_and_stop();
  end
endmodule // testbench

`default_nettype wire
